/* File: design/sacc_top.sv */
// Stand-alone clock configuration, frame and bit clock generation
// Notes on behaviour
// - After reset release the block waits 1045 sample periods before entering stand-alone operation.
// - In master role the block drives frame and bit clocks, generated from master clock edges.
// - In master role the frame clock runs at the sample rate and the bit clock at 64 times it.
// - The role strap on the serial data output pin selects master when pulled up, slave when pulled down.
// - Sample rates fall into single, double and quad speed modes.
// - In master single speed the ratio pins select 256, 384, 512 or 1024 master clocks per frame.
// - Double speed halves and quad speed quarters those ratios, bit clock staying at 64 per frame.
// - In stand-alone operation the fast roll-off interpolation filter is always used.
// - In master role the speed pins select single, single with de-emphasis, double or quad speed.
// - In slave role speed is detected from the clocks and the low speed pin selects de-emphasis.
`timescale 1ns/1ps
`default_nettype none
`include "sacc_defines.svh"
module sacc_top #(
  parameter int WAIT_PERIODS = `SACC_WAIT_PERIODS
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic mclk_pin,
  input wire logic ratio_select_hi,
  input wire logic ratio_select_lo,
  input wire logic speed_pin_hi,
  input wire logic speed_pin_lo,
  input wire logic frame_clock_i,
  output logic frame_clock_o,
  output logic frame_clock_oe,
  input wire logic bit_clock_i,
  output logic bit_clock_o,
  output logic bit_clock_oe,
  input wire logic serial_data_out_i,
  output logic serial_data_out_o,
  output logic serial_data_out_oe,
  input wire logic tx_data,
  output sacc_pkg::sacc_cfg_t cfg_ff
);
  // ==========================================================
  // Ratio lookup
  function automatic logic [`SACC_RATIO_W-1:0] ratio_of(input sacc_pkg::sacc_speed_t spd, input logic [1:0] code);
    logic [`SACC_RATIO_W-1:0] base;
    base = `SACC_BASE_RATIO_00;
    case (code)
      2'h0: base = `SACC_BASE_RATIO_00;
      2'h1: base = `SACC_BASE_RATIO_01;
      2'h2: base = `SACC_BASE_RATIO_10;
      default: base = `SACC_BASE_RATIO_11;
    endcase
    case (spd)
      sacc_pkg::SACC_SPEED_DOUBLE: ratio_of = base >> 1;
      sacc_pkg::SACC_SPEED_QUAD: ratio_of = base >> 2;
      default: ratio_of = base;
    endcase
  endfunction : ratio_of

  // ==========================================================
  // Input synchronisers
  localparam int NSYNC = 8;
  logic [NSYNC-1:0] sync1_ff;
  logic [NSYNC-1:0] sync2_ff;
  logic [2:0] prev_ff;
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sync1_ff <= '0;
      sync2_ff <= '0;
      prev_ff <= '0;
    end else begin
      sync1_ff <= {mclk_pin, frame_clock_i, bit_clock_i, serial_data_out_i,
                   ratio_select_hi, ratio_select_lo, speed_pin_hi, speed_pin_lo};
      sync2_ff <= sync1_ff;
      prev_ff <= sync2_ff[7:5];
    end
  end
  logic mclk_s;
  logic frame_s;
  logic strap_s;
  logic mclk_rise;
  logic mclk_edge;
  logic frame_rise;
  assign mclk_s = sync2_ff[7];
  assign frame_s = sync2_ff[6];
  assign strap_s = sync2_ff[4];
  assign mclk_rise = mclk_s & ~prev_ff[2];
  assign mclk_edge = mclk_s ^ prev_ff[2];
  assign frame_rise = frame_s & ~prev_ff[1];

  // ==========================================================
  // Startup sequencing
  sacc_pkg::sacc_state_t state_ff;
  logic [1:0] sync_cnt_ff;
  logic [15:0] wait_cnt_ff;
  logic [`SACC_RATIO_W-1:0] per_cnt_ff;
  logic [`SACC_RATIO_W-1:0] ratio_ff;
  logic [`SACC_RATIO_W-1:0] meas_ff;
  logic [`SACC_RATIO_W-1:0] meas_cnt_ff;
  logic strap_master_ff;
  logic [1:0] strap_ratio_ff;
  logic [1:0] strap_speed_ff;
  logic period_tick;
  logic wait_done;
  sacc_pkg::sacc_speed_t pin_speed;
  sacc_pkg::sacc_speed_t det_speed;

  assign pin_speed = strap_speed_ff[1] ? (strap_speed_ff[0] ? sacc_pkg::SACC_SPEED_QUAD : sacc_pkg::SACC_SPEED_DOUBLE)
                                       : sacc_pkg::SACC_SPEED_SINGLE;
  assign det_speed = (meas_ff == ratio_of(sacc_pkg::SACC_SPEED_SINGLE, strap_ratio_ff)) ? sacc_pkg::SACC_SPEED_SINGLE :
                     (meas_ff == ratio_of(sacc_pkg::SACC_SPEED_DOUBLE, strap_ratio_ff)) ? sacc_pkg::SACC_SPEED_DOUBLE :
                     sacc_pkg::SACC_SPEED_QUAD;
  // one sample period per master frame or incoming frame
  assign period_tick = strap_master_ff ? (mclk_rise && per_cnt_ff == ratio_ff - 1'b1) : frame_rise;
  assign wait_done = period_tick && wait_cnt_ff == 16'(WAIT_PERIODS - 1);

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_ff <= sacc_pkg::SACC_ST_SYNC;
      sync_cnt_ff <= '0;
      wait_cnt_ff <= '0;
    end else begin
      case (state_ff)
        sacc_pkg::SACC_ST_SYNC: begin
          sync_cnt_ff <= sync_cnt_ff + 2'h1;
          if (sync_cnt_ff == `SACC_SYNC_CYCLES) begin
            state_ff <= sacc_pkg::SACC_ST_WAIT;
          end
        end
        sacc_pkg::SACC_ST_WAIT: begin
          if (wait_done) begin
            state_ff <= sacc_pkg::SACC_ST_RUN;
          end else if (period_tick) begin
            wait_cnt_ff <= wait_cnt_ff + 16'h0001;
          end
        end
        sacc_pkg::SACC_ST_RUN: state_ff <= sacc_pkg::SACC_ST_RUN;
        default: state_ff <= sacc_pkg::SACC_ST_SYNC;
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      strap_master_ff <= 1'b0;
      strap_ratio_ff <= 2'h0;
      strap_speed_ff <= 2'h0;
      ratio_ff <= `SACC_BASE_RATIO_00;
    end else if (state_ff == sacc_pkg::SACC_ST_SYNC && sync_cnt_ff == `SACC_SYNC_CYCLES) begin
      strap_master_ff <= strap_s;
      strap_ratio_ff <= sync2_ff[3:2];
      strap_speed_ff <= sync2_ff[1:0];
      ratio_ff <= ratio_of(sync2_ff[1] ? (sync2_ff[0] ? sacc_pkg::SACC_SPEED_QUAD : sacc_pkg::SACC_SPEED_DOUBLE)
                                       : sacc_pkg::SACC_SPEED_SINGLE, sync2_ff[3:2]);
    end
  end

  // Master period counter and slave ratio measurement
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      per_cnt_ff <= '0;
      meas_cnt_ff <= '0;
      meas_ff <= '0;
    end else if (state_ff == sacc_pkg::SACC_ST_WAIT) begin
      if (mclk_rise) begin
        per_cnt_ff <= (per_cnt_ff == ratio_ff - 1'b1) ? '0 : per_cnt_ff + 1'b1;
      end
      if (frame_rise) begin
        meas_ff <= meas_cnt_ff;
        meas_cnt_ff <= mclk_rise ? 11'h001 : 11'h000;
      end else if (mclk_rise && meas_cnt_ff != `SACC_MEAS_MAX) begin
        meas_cnt_ff <= meas_cnt_ff + 1'b1;
      end
    end
  end

  // ==========================================================
  // Configuration outputs
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cfg_ff <= '0;
    end else if (state_ff == sacc_pkg::SACC_ST_WAIT && wait_done) begin
      cfg_ff.active <= 1'b1;
      cfg_ff.master <= strap_master_ff;
      cfg_ff.ratio_code <= strap_ratio_ff;
      cfg_ff.speed <= strap_master_ff ? pin_speed : det_speed;
      cfg_ff.deemph_44k <= strap_master_ff ? (strap_speed_ff == 2'h1) : strap_speed_ff[0];
      cfg_ff.fast_rolloff <= 1'b1;
    end
  end

  // ==========================================================
  // Master clock generation
  logic [11:0] acc_ff;
  logic [5:0] half_cnt_ff;
  logic [11:0] two_n;
  logic [11:0] acc_sum;
  logic gen_run;
  assign two_n = {ratio_ff, 1'b0};
  assign acc_sum = acc_ff + `SACC_BCLK_HALF_STEP;
  assign gen_run = cfg_ff.active && cfg_ff.master;

  // bit clock toggles 128 times per frame from mclk edges
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      acc_ff <= '0;
      half_cnt_ff <= '0;
      bit_clock_o <= 1'b0;
      frame_clock_o <= 1'b0;
    end else if (gen_run && mclk_edge) begin
      if (acc_sum >= two_n) begin
        acc_ff <= acc_sum - two_n;
        bit_clock_o <= ~bit_clock_o;
        half_cnt_ff <= half_cnt_ff + 6'h01;
        // frame edge on a bit clock fall
        if (half_cnt_ff == `SACC_HALF_BITS_PER_SIDE) begin
          frame_clock_o <= ~frame_clock_o;
        end
      end else begin
        acc_ff <= acc_sum;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      frame_clock_oe <= 1'b0;
      bit_clock_oe <= 1'b0;
      serial_data_out_oe <= 1'b0;
      serial_data_out_o <= 1'b0;
    end else begin
      frame_clock_oe <= gen_run;
      bit_clock_oe <= gen_run;
      serial_data_out_oe <= cfg_ff.active;
      serial_data_out_o <= cfg_ff.active & tx_data;
    end
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  a_wait_before_run: assert property ($rose(cfg_ff.active) |-> $past(wait_cnt_ff) == 16'(WAIT_PERIODS - 1))
    else $error("stand-alone entered before wait elapsed");
  a_master_drives_clk: assert property (gen_run |=> frame_clock_oe && bit_clock_oe)
    else $error("master not driving clocks");
  a_frame_on_bit_fall: assert property ($changed(frame_clock_o) |-> $fell(bit_clock_o) && $past(half_cnt_ff) == 6'h3F)
    else $error("frame edge misplaced");
  a_slave_releases_pins: assert property (cfg_ff.active && !cfg_ff.master |=> !frame_clock_oe && !bit_clock_oe)
    else $error("slave drives clock pins");
  a_speed_legal: assert property (cfg_ff.active |-> cfg_ff.speed != 2'h3)
    else $error("illegal speed mode");
  a_master_ratio: assert property (gen_run |-> ratio_ff == ratio_of(cfg_ff.speed, cfg_ff.ratio_code))
    else $error("master ratio mismatch");
  a_quad_ratio: assert property (gen_run && cfg_ff.speed == sacc_pkg::SACC_SPEED_QUAD |-> ratio_ff <= 11'h100)
    else $error("quad ratio out of range");
  a_fast_filter_on: assert property (cfg_ff.active |-> cfg_ff.fast_rolloff)
    else $error("filter not fast roll-off");
  a_master_speed_pins: assert property ($rose(cfg_ff.active) && cfg_ff.master |-> cfg_ff.speed == pin_speed)
    else $error("speed does not follow pins");
  a_slave_deemph_pin: assert property ($rose(cfg_ff.active) && !cfg_ff.master |-> cfg_ff.deemph_44k == strap_speed_ff[0])
    else $error("slave de-emphasis wrong");
  a_cfg_held: assert property (cfg_ff.active |=> $stable(cfg_ff))
    else $error("configuration changed while running");

  // Strap capture on leaving reset
  sequence s_strap_latch;
    state_ff == sacc_pkg::SACC_ST_SYNC && sync_cnt_ff == `SACC_SYNC_CYCLES;
  endsequence
  sequence s_strap_taken;
    strap_master_ff == $past(strap_s) && strap_ratio_ff == $past(sync2_ff[3:2]);
  endsequence
  a_strap_latched: assert property (s_strap_latch |=> s_strap_taken)
    else $error("straps not latched on leaving reset");
endmodule : sacc_top
`default_nettype wire

/* File: design/sacc_defines.svh */
// Constants for the stand-alone audio clock configuration block
`ifndef SACC_DEFINES_SVH
`define SACC_DEFINES_SVH
`define SACC_WAIT_PERIODS 1045
`define SACC_RATIO_W 11
`define SACC_BASE_RATIO_00 11'h100
`define SACC_BASE_RATIO_01 11'h180
`define SACC_BASE_RATIO_10 11'h200
`define SACC_BASE_RATIO_11 11'h400
`define SACC_BCLK_PER_FRAME 64
`define SACC_BCLK_HALF_STEP 12'h080
`define SACC_HALF_BITS_PER_SIDE 6'h3F
`define SACC_SYNC_CYCLES 2'h2
`define SACC_MEAS_MAX 11'h7FF
`endif

/* File: design/sacc_pkg.sv */
// Types for the stand-alone audio clock configuration block
`default_nettype none
package sacc_pkg;
  typedef enum logic [1:0] {
    SACC_SPEED_SINGLE = 2'h0,
    SACC_SPEED_DOUBLE = 2'h1,
    SACC_SPEED_QUAD = 2'h2
  } sacc_speed_t;

  typedef enum logic [1:0] {
    SACC_ST_SYNC = 2'h0,
    SACC_ST_WAIT = 2'h1,
    SACC_ST_RUN = 2'h2
  } sacc_state_t;

  typedef struct packed {
    logic active;
    logic master;
    logic [1:0] ratio_code;
    sacc_speed_t speed;
    logic deemph_44k;
    logic fast_rolloff;
  } sacc_cfg_t;
endpackage : sacc_pkg
`default_nettype wire

/* File: verif/sacc_far_end.sv */
// Far-end audio processor: master clock and slave-role serial clocks
`timescale 1ns/1ps
`default_nettype none
module sacc_far_end (
  input wire logic slave_en,
  input wire logic [10:0] ratio,
  output logic mclk_pin,
  output logic frame_clock,
  output logic bit_clock
);
  int cnt;
  initial begin
    mclk_pin = 1'b0;
    #3.1;
    forever #24 mclk_pin = ~mclk_pin;
  end
  always @(posedge mclk_pin or negedge slave_en) begin
    if (!slave_en) cnt <= 0;
    else cnt <= (cnt == ratio - 1) ? 0 : cnt + 1;
  end
  assign frame_clock = slave_en && cnt >= ratio / 2;
  assign bit_clock = slave_en && (cnt % (ratio / 64)) >= ratio / 128;
endmodule : sacc_far_end
`default_nettype wire

/* File: verif/standalone_audio_clock_config_tb_top.sv */
// Self-checking bench for stand-alone role, ratio and clock generation
`timescale 1ns/1ps
`default_nettype none
module standalone_audio_clock_config_tb_top;
  localparam int WAITP = 4;
  logic sys_clk, sys_rst, tx_data, strap, slave_en, act_d;
  logic [3:0] pins;
  logic [1:0] sp;
  logic [10:0] ratio, r;
  logic [10:0] base [4] = '{11'h100, 11'h180, 11'h200, 11'h400};
  wire logic mclk_pin, p_frame, p_bit, frame_pin, bit_pin, sdo_pin;
  logic frame_o, frame_oe, bit_o, bit_oe, sdo_o, sdo_oe;
  sacc_pkg::sacc_cfg_t cfg_ff;
  sacc_pkg::sacc_cfg_t exp_q[$];
  logic dq[$];
  int err_total, num_checks, mclk_rises, frame_rises;
  // ==========================================
  // Wiring
  assign frame_pin = frame_oe ? frame_o : (slave_en ? p_frame : ~mclk_pin);
  assign bit_pin = bit_oe ? bit_o : (slave_en ? p_bit : mclk_pin);
  assign sdo_pin = sdo_oe ? sdo_o : strap;
  sacc_top #(.WAIT_PERIODS(WAITP)) uut (.sys_clk(sys_clk), .sys_rst(sys_rst), .mclk_pin(mclk_pin),
    .ratio_select_hi(pins[3]), .ratio_select_lo(pins[2]), .speed_pin_hi(pins[1]), .speed_pin_lo(pins[0]),
    .frame_clock_i(frame_pin), .frame_clock_o(frame_o), .frame_clock_oe(frame_oe), .bit_clock_i(bit_pin),
    .bit_clock_o(bit_o), .bit_clock_oe(bit_oe), .serial_data_out_i(sdo_pin), .serial_data_out_o(sdo_o),
    .serial_data_out_oe(sdo_oe), .tx_data(tx_data), .cfg_ff(cfg_ff));
  sacc_far_end u_far (.slave_en(slave_en), .ratio(ratio), .mclk_pin(mclk_pin), .frame_clock(p_frame),
    .bit_clock(p_bit));
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  always @(posedge mclk_pin) mclk_rises++;
  always @(posedge frame_pin) frame_rises++;
  // ==========================================
  // Checks
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : print_verdict
  task automatic give_up();
    chk(16'h0000, 16'h0001);
    print_verdict();
  endtask : give_up
  always @(negedge sys_clk) begin
    act_d <= cfg_ff.active;
    if (cfg_ff.active === 1'b1 && act_d === 1'b0) begin
      if (exp_q.size() == 0) give_up();
      else chk(16'(cfg_ff), 16'(exp_q.pop_front()));
    end
  end
  always @(posedge sys_clk) begin
    #1;
    if (dq.size() > 0) chk(16'(sdo_o), 16'(dq.pop_front()));
  end
  // ==========================================
  // Stimulus
  task automatic start(input logic mst, input logic [3:0] p, input logic [10:0] rr, input sacc_pkg::sacc_cfg_t e);
    int m0, f0, n;
    @(negedge sys_clk);
    sys_rst = 1'b1;
    slave_en = 1'b0;
    strap = mst;
    pins = p;
    ratio = rr;
    exp_q.push_back(e);
    repeat (6) @(negedge sys_clk);
    sys_rst = 1'b0;
    slave_en = ~mst;
    m0 = mclk_rises;
    f0 = frame_rises;
    for (n = 0; n < 40000 && cfg_ff.active !== 1'b1; n++) @(negedge sys_clk);
    if (n >= 40000) give_up();
    if (mst) chk(16'((mclk_rises - m0) >= WAITP * rr && (mclk_rises - m0) <= WAITP * rr + 2), 16'h0001);
    else chk(16'(frame_rises - f0), 16'(WAITP));
    repeat (3) @(negedge sys_clk);
    chk(16'({frame_oe, bit_oe, sdo_oe}), 16'({mst, mst, 1'b1}));
    pins = ~p;
    repeat (20) @(negedge sys_clk);
    chk(16'(cfg_ff), 16'(e));
  endtask : start
  task automatic measure(input logic [10:0] rr);
    int m0, tog, rises, n;
    logic fp, bp;
    rises = 0;
    tog = 0;
    m0 = 0;
    fp = frame_o;
    bp = bit_o;
    for (n = 0; n < 40000 && rises < 2; n++) begin
      @(negedge sys_clk);
      if (bit_o !== bp) tog++;
      if (frame_o === 1'b1 && fp === 1'b0) begin
        rises++;
        if (rises == 1) m0 = mclk_rises;
        if (rises == 1) tog = 0;
        chk(16'(bit_o), 16'h0000);
      end
      fp = frame_o;
      bp = bit_o;
    end
    if (rises < 2) give_up();
    chk(16'(tog), 16'h0080);
    chk(16'((mclk_rises - m0) + 1 >= rr && (mclk_rises - m0) <= rr + 1), 16'h0001);
  endtask : measure
  task automatic send_data(input int k);
    repeat (k) begin
      @(negedge sys_clk);
      tx_data = 1'($urandom);
      dq.push_back(tx_data);
    end
    @(negedge sys_clk);
  endtask : send_data
  initial begin
    sys_rst = 1'b1;
    tx_data = 1'b0;
    strap = 1'b0;
    slave_en = 1'b0;
    pins = 4'h0;
    ratio = 11'h100;
    void'($urandom(32'h4A21DFFB));
    for (int i = 0; i < 4; i++) begin
      sp = (i == 3) ? 2'h2 : (i == 2) ? 2'h1 : 2'h0;
      r = base[i] >> sp;
      start(1'b1, {2'(i), 2'(i)}, r, '{1'b1, 1'b1, 2'(i), sacc_pkg::sacc_speed_t'(sp), i == 1, 1'b1});
      measure(r);
      send_data(16);
    end
    for (int i = 0; i < 3; i++) begin
      start(1'b0, {3'h0, 1'(~i)}, 11'h100 >> i, '{1'b1, 1'b0, 2'h0, sacc_pkg::sacc_speed_t'(i), 1'(~i), 1'b1});
      send_data(16);
    end
    chk(16'(exp_q.size()), 16'h0000);
    print_verdict();
  end
endmodule : standalone_audio_clock_config_tb_top
`default_nettype wire
